// *** hsc_command_port.sv ***
// Operation
// R1 - ack matching address before read data
// R2 - send bytes until master answers nack
// R3 - bytes 0-1 carry status plus humidity
// R4 - byte 2 carries temperature upper eight bits
// R5 - byte 3 holds six temperature lsbs
// R6 - results are 14-bit full-scale counts
// R7 - address-only write is wake request
// R8 - wake acted on only in sleep mode
// R9 - wake runs one full measurement cycle
// R10 - ready rises on results, held until readout
// R11 - ready driver push-pull or open-drain by config
// R12 - ready rises when a command finishes
// R13 - command is address, byte, 16-bit data
// R14 - 0x16-0x1F reads word within 100 us
// R15 - 0x56-0x5F writes word within 12 ms
// R16 - 0x80 leaves session to normal operation
// R17 - 0xA0 enters session only in window
// R18 - response byte: 10, four flags, code
// R19 - codes busy, success, refused
// R20 - diagnostic flags in bits 2 to 5
// R21 - master waits out previous command first
// R22 - word read returns two bytes after response
// R23 - status fresh, stale or session
// R24 - power-on window 10 ms or 3 ms
// R25 - sleep mode stays down after readout
// R26 - response byte kept until next command
`timescale 1ns/1ps
module hsc_command_port
#(
    parameter int READ_CYC_P   = hsc_pkg::READ_CYC,
    parameter int ENTER_CYC_P  = hsc_pkg::ENTER_CYC,
    parameter int WRITE_CYC_P  = hsc_pkg::WRITE_CYC,
    parameter int WINDOW_CYC_P = hsc_pkg::WINDOW_CYC,
    parameter int QUICK_CYC_P  = hsc_pkg::QUICK_CYC
)
(
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       scl,
    input  wire logic                       sdaIn,
    output logic                            sdaOut,
    output logic                            sdaOe,
    output logic                            readyOut,
    output logic                            readyOe,
    output logic                            measReq,
    output logic                            coreAwake,
    input  wire logic                       measDone,
    input  wire logic [hsc_pkg::DATA_W-1:0] humIn,
    input  wire logic [hsc_pkg::DATA_W-1:0] tempIn,
    input  wire logic                       nvLocked,
    input  wire logic [3:0]                 diagIn
);
    import hsc_pkg::*;

    // counters are CNT_W wide; anything longer cannot be timed
    if (READ_CYC_P < 1 || ENTER_CYC_P < 1 || WRITE_CYC_P >= 2**CNT_W
        || WINDOW_CYC_P >= 2**CNT_W || QUICK_CYC_P < 1 || WRITE_CYC_P < 1
        || QUICK_CYC_P >= 2**CNT_W || WINDOW_CYC_P < 1 || READ_CYC_P >= 2**CNT_W
        || ENTER_CYC_P >= 2**CNT_W)
        $error("hsc_command_port: cycle count out of range");

    logic             sclMeta, sclS, sclD, sdaMeta, sdaS, sdaD;
    hsc_link_t        lkState;
    hsc_mode_t        mode;
    logic [3:0]       bitCnt;
    logic [2:0]       byteIdx;
    logic [7:0]       rxShift, txShift, cmdByte, dataHi, dataLo, curByte;
    logic             isAddr, isRead, addressed, readPulse, wakePulse, cmdPulse;
    logic [1:0]       rdStatus, rspCode;
    logic [3:0]       rspDiag;
    logic [15:0]      nv [NV_WORDS];
    logic [15:0]      wordOut, wrData;
    logic [3:0]       wrIdx;
    logic             cmdBusy, cmdDone, pendWrite, nvWrite, lastRead, ready, fresh;
    logic [CNT_W-1:0] cmdTimer, winCnt;
    logic [DATA_W-1:0] humData, tempData;
    logic             sclRise, sclFall, start, stop, winDone, startMeas;
    logic             isRdCmd, isWrCmd, zeroData, cmdTake, enterOk, leaveOk;
    logic [3:0]       cmdIdx;
    logic [6:0]       devAddr;
    logic             sleepMode;

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers; the bus clock is only sampled, never used as a clock
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclMeta <= 1'b1;
            sclS    <= 1'b1;
            sclD    <= 1'b1;
            sdaMeta <= 1'b1;
            sdaS    <= 1'b1;
            sdaD    <= 1'b1;
        end
        else
        begin
            sclMeta <= scl;
            sclS    <= sclMeta;
            sclD    <= sclS;
            sdaMeta <= sdaIn;
            sdaS    <= sdaMeta;
            sdaD    <= sdaS;
        end
    end

    // bus events and configuration taps
    assign sclRise   = sclS & ~sclD;
    assign sclFall   = ~sclS & sclD;
    assign start     = sclS & sclD & sdaD & ~sdaS;
    assign stop      = sclS & sclD & ~sdaD & sdaS;
    assign devAddr   = nv[CFG_IDX][CFG_ADDR_MSB:0];
    assign sleepMode = nv[CFG_IDX][CFG_SLEEP_BIT];

    //////////////////////////////////////////////////////////////////////////
    // readout byte selection; beyond the defined bytes the port sends zeros
    always_comb
    begin
        curByte = 8'h00;
        if (mode == MD_SESSION)
        begin
            if (byteIdx == 3'h0)
                curByte = {ST_SESSION, rspDiag, rspCode};       // R18 R20 R26
            else if (byteIdx == 3'h1 && lastRead)
                curByte = wordOut[15:8];                        // R22
            else if (byteIdx == 3'h2 && lastRead)
                curByte = wordOut[7:0];                         // R22
        end
        else if (byteIdx == 3'h0)
            curByte = {rdStatus, humData[13:8]};                // R3 R6
        else if (byteIdx == 3'h1)
            curByte = humData[7:0];                             // R3
        else if (byteIdx == 3'h2)
            curByte = tempData[13:6];                           // R4
        else if (byteIdx == 3'h3)
            curByte = {tempData[5:0], 2'h0};                    // R5
    end

    //////////////////////////////////////////////////////////////////////////
    // bus target: shifts in on scl rise, changes sda only after scl falls
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lkState   <= LK_IDLE;
            bitCnt    <= 4'h0;
            byteIdx   <= 3'h0;
            rxShift   <= 8'h00;
            txShift   <= 8'h00;
            cmdByte   <= 8'h00;
            dataHi    <= 8'h00;
            dataLo    <= 8'h00;
            isAddr    <= 1'b0;
            isRead    <= 1'b0;
            addressed <= 1'b0;
            rdStatus  <= ST_FRESH;
            sdaOe     <= 1'b0;
            sdaOut    <= 1'b0;
            readPulse <= 1'b0;
            wakePulse <= 1'b0;
            cmdPulse  <= 1'b0;
        end
        else
        begin
            readPulse <= 1'b0;
            wakePulse <= 1'b0;
            cmdPulse  <= 1'b0;
            if (start)
            begin
                lkState   <= LK_RX;
                bitCnt    <= 4'h0;
                byteIdx   <= 3'h0;
                isAddr    <= 1'b1;
                addressed <= 1'b0;
                sdaOe     <= 1'b0;
            end
            else if (stop)
            begin
                lkState   <= LK_IDLE;
                sdaOe     <= 1'b0;
                addressed <= 1'b0;
                cmdPulse  <= addressed & ~isRead & (byteIdx == 3'h3);  // R13
            end
            else
            begin
                case (lkState)
                    LK_RX:
                        if (sclRise)
                        begin
                            rxShift <= {rxShift[6:0], sdaS};
                            bitCnt  <= bitCnt + 4'h1;
                        end
                        else if (sclFall && bitCnt == 4'h8)
                        begin
                            if (isAddr && rxShift[7:1] != devAddr)
                                lkState <= LK_IDLE;             // foreign address
                            else
                            begin
                                sdaOe   <= 1'b1;                // R1 R7
                                lkState <= LK_RXACK;
                                if (isAddr)
                                begin
                                    isRead    <= rxShift[0];
                                    addressed <= 1'b1;
                                    readPulse <= rxShift[0];
                                    wakePulse <= ~rxShift[0];   // R7
                                    rdStatus  <= fresh ? ST_FRESH : ST_STALE;  // R23
                                end
                                else
                                begin
                                    if (byteIdx == 3'h0)
                                        cmdByte <= rxShift;
                                    else if (byteIdx == 3'h1)
                                        dataHi <= rxShift;
                                    else if (byteIdx == 3'h2)
                                        dataLo <= rxShift;
                                    if (byteIdx != 3'h7)
                                        byteIdx <= byteIdx + 3'h1;
                                end
                            end
                        end
                    LK_RXACK:
                        if (sclFall)
                        begin
                            bitCnt <= 4'h0;
                            isAddr <= 1'b0;
                            if (isRead)
                            begin
                                txShift <= curByte;
                                sdaOe   <= ~curByte[7];         // R1
                                lkState <= LK_TX;
                            end
                            else
                            begin
                                sdaOe   <= 1'b0;
                                lkState <= LK_RX;
                            end
                        end
                    LK_TX:
                        if (sclFall)
                        begin
                            if (bitCnt == 4'h7)
                            begin
                                sdaOe   <= 1'b0;                // free sda for master ack
                                lkState <= LK_TXACK;
                            end
                            else
                            begin
                                bitCnt  <= bitCnt + 4'h1;
                                txShift <= {txShift[6:0], 1'b0};
                                sdaOe   <= ~txShift[6];
                            end
                        end
                    LK_TXACK:
                        if (sclRise)
                        begin
                            if (sdaS)
                                lkState <= LK_IDLE;             // R2
                            else if (byteIdx != 3'h7)
                                byteIdx <= byteIdx + 3'h1;
                        end
                        else if (sclFall)
                        begin
                            bitCnt  <= 4'h0;
                            txShift <= curByte;                 // R2
                            sdaOe   <= ~curByte[7];
                            lkState <= LK_TX;
                        end
                    default:
                        lkState <= LK_IDLE;
                endcase
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // command decode; a command arriving while one runs is dropped
    assign cmdIdx   = 4'(cmdByte[5:0] - 6'h16);
    assign isRdCmd  = cmdByte >= CMD_RD_LO && cmdByte <= CMD_RD_HI;
    assign isWrCmd  = cmdByte >= CMD_WR_LO && cmdByte <= CMD_WR_HI;
    assign zeroData = {dataHi, dataLo} == 16'h0000;
    // a malformed entry packet is ignored so the response code never sticks at busy
    assign cmdTake  = cmdPulse & ~cmdBusy & (mode == MD_SESSION ||
                      (mode == MD_WINDOW && cmdByte == CMD_ENTER && zeroData)); // R17 R21
    assign enterOk  = cmdTake & (mode == MD_WINDOW) & zeroData;          // R17
    assign leaveOk  = cmdTake & (mode == MD_SESSION) & (cmdByte == CMD_LEAVE) & zeroData;
    assign winDone  = winCnt == (nv[CFG_IDX][CFG_QUICK_BIT] ? CNT_W'(QUICK_CYC_P)
                                                            : CNT_W'(WINDOW_CYC_P));

    // command execution timer and response byte
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmdBusy   <= 1'b0;
            cmdDone   <= 1'b0;
            cmdTimer  <= '0;
            rspCode   <= RSP_OK;
            rspDiag   <= 4'h0;
            wordOut   <= 16'h0000;
            lastRead  <= 1'b0;
            pendWrite <= 1'b0;
            nvWrite   <= 1'b0;
            wrIdx     <= 4'h0;
            wrData    <= 16'h0000;
        end
        else
        begin
            cmdDone <= 1'b0;
            nvWrite <= 1'b0;
            if (cmdTake)
            begin
                lastRead  <= 1'b0;
                pendWrite <= 1'b0;
                rspCode   <= RSP_BUSY;                          // R19
                if (mode == MD_WINDOW)
                begin
                    cmdBusy  <= zeroData;
                    cmdTimer <= CNT_W'(ENTER_CYC_P);            // R17
                end
                else if (isRdCmd && zeroData)
                begin
                    cmdBusy  <= 1'b1;
                    cmdTimer <= CNT_W'(READ_CYC_P);             // R14
                    wordOut  <= nv[cmdIdx];
                    lastRead <= 1'b1;
                end
                else if (isWrCmd && !nvLocked)
                begin
                    cmdBusy   <= 1'b1;
                    cmdTimer  <= CNT_W'(WRITE_CYC_P);           // R15
                    pendWrite <= 1'b1;
                    wrIdx     <= cmdIdx;
                    wrData    <= {dataHi, dataLo};
                end
                else
                begin
                    cmdDone <= 1'b1;                            // R12
                    rspCode <= leaveOk ? RSP_OK : RSP_NAK;      // R19
                    rspDiag <= diagIn;
                end
            end
            else if (cmdBusy)
            begin
                if (cmdTimer == CNT_W'(1))
                begin
                    cmdBusy <= 1'b0;
                    cmdDone <= 1'b1;                            // R12
                    rspCode <= RSP_OK;                          // R19
                    rspDiag <= diagIn;                          // R20
                    nvWrite <= pendWrite;                       // R15
                end
                cmdTimer <= cmdTimer - CNT_W'(1);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // nonvolatile words, one writer per word
    for (genvar i = 0; i < NV_WORDS; i++)
    begin : g_nv
        always_ff @(posedge mclk or negedge rst_n)
        begin
            if (!rst_n)
                nv[i] <= NV_RESET[i];
            else if (nvWrite && wrIdx == 4'(i))
                nv[i] <= wrData;                                // R15
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // operating mode: power-on window, session, normal
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode   <= MD_WINDOW;
            winCnt <= '0;
        end
        else
        begin
            case (mode)
                MD_WINDOW:
                begin
                    winCnt <= winCnt + CNT_W'(1);
                    if (enterOk)
                        mode <= MD_SESSION;                     // R17
                    else if (winDone)
                        mode <= MD_NORMAL;                      // R24
                end
                MD_SESSION:
                    if (leaveOk)
                        mode <= MD_NORMAL;                      // R16
                default:
                    mode <= MD_NORMAL;
            endcase
        end
    end

    // measurement requests toward the conversion core
    assign startMeas = ((mode == MD_WINDOW) & winDone & ~enterOk) | leaveOk |
                       ((mode == MD_NORMAL) & ~coreAwake & (~sleepMode | wakePulse)); // R8 R25

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            measReq   <= 1'b0;
            coreAwake <= 1'b0;
        end
        else
        begin
            measReq <= startMeas;                               // R9
            if (startMeas)
                coreAwake <= 1'b1;
            else if (measDone)
                coreAwake <= 1'b0;                              // powered down after cycle
        end
    end

    // results, freshness and the ready level; a set beats a same-cycle clear
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            humData  <= '0;
            tempData <= '0;
            fresh    <= 1'b0;
            ready    <= 1'b0;
            readyOut <= 1'b0;
            readyOe  <= 1'b0;
        end
        else
        begin
            if (measDone)
            begin
                humData  <= humIn;                              // R6
                tempData <= tempIn;                             // R6
            end
            fresh <= measDone | (fresh & ~readPulse);           // R23
            ready <= measDone | cmdDone | (ready & ~readPulse); // R10 R12
            readyOut <= nv[CFG_IDX][CFG_RDYOD_BIT] ? 1'b0 : ready;    // R11
            readyOe  <= nv[CFG_IDX][CFG_RDYOD_BIT] ? ~ready : 1'b1;   // R11
        end
    end

    //////////////////////////////////////////////////////////////////////////
    a_addr_ack: assert property (@(posedge mclk) disable iff (!rst_n) // R1
        (lkState == LK_RX && sclFall && bitCnt == 4'h8 && isAddr && !start && !stop
         && rxShift[7:1] == devAddr) |=> sdaOe && lkState == LK_RXACK)
        else $error("matching address not acknowledged");
    a_humid_low: assert property (@(posedge mclk) disable iff (!rst_n) // R3
        (lkState == LK_TXACK && sclFall && !start && !stop && mode != MD_SESSION
         && byteIdx == 3'h1) |=> txShift == $past(humData[7:0]))
        else $error("second readout byte is not humidity low byte");
    a_temp_low: assert property (@(posedge mclk) disable iff (!rst_n) // R5
        (lkState == LK_TXACK && sclFall && !start && !stop && mode != MD_SESSION
         && byteIdx == 3'h3) |=> txShift == {$past(tempData[5:0]), 2'h0})
        else $error("fourth readout byte misplaced");
    a_ready_hold: assert property (@(posedge mclk) disable iff (!rst_n) // R10
        (ready && !readPulse) |=> ready[*3] or ##[1:2] $past(readPulse))
        else $error("ready dropped without readout");
    a_ready_rise: assert property (@(posedge mclk) disable iff (!rst_n) // R12
        (cmdDone || measDone) |=> ready ##2 (readyOut || !readyOe || $past(readPulse, 2)))
        else $error("ready did not rise after completion");
    a_busy_code: assert property (@(posedge mclk) disable iff (!rst_n) // R19
        cmdBusy |-> mode == MD_SESSION && rspCode == RSP_BUSY
            && (byteIdx != 3'h0 || curByte == {ST_SESSION, rspDiag, RSP_BUSY}))
        else $error("busy command not reported as busy");
    a_wake_sleep: assert property (@(posedge mclk) disable iff (!rst_n) // R8
        (mode == MD_NORMAL && sleepMode && !coreAwake && !wakePulse) |=> !measReq)
        else $error("sleep mode measured without wake request");
    a_window_end: assert property (@(posedge mclk) disable iff (!rst_n) // R24
        (mode == MD_WINDOW && winDone && !enterOk) |=> mode == MD_NORMAL && measReq)
        else $error("window expiry did not start normal operation");
endmodule

// *** hsc_pkg.sv ***
package hsc_pkg;
    // clock and timing
    localparam int CLK_MHZ       = 200;
    localparam int READ_TIME_US  = 100;
    localparam int ENTER_TIME_US = 100;
    localparam int WRITE_TIME_MS = 12;
    localparam int WINDOW_MS     = 10;
    localparam int QUICK_MS      = 3;
    localparam int READ_CYC      = READ_TIME_US * CLK_MHZ;
    localparam int ENTER_CYC     = ENTER_TIME_US * CLK_MHZ;
    localparam int WRITE_CYC     = WRITE_TIME_MS * 1000 * CLK_MHZ;
    localparam int WINDOW_CYC    = WINDOW_MS * 1000 * CLK_MHZ;
    localparam int QUICK_CYC     = QUICK_MS * 1000 * CLK_MHZ;
    localparam int CNT_W         = 24;

    // nonvolatile word map
    localparam int NV_WORDS = 10;
    localparam logic [7:0] ADR_DENSITY_OUT_UPPER_LIMIT  = 8'h16;
    localparam logic [7:0] ADR_DENSITY_OUT_LOWER_LIMIT  = 8'h17;
    localparam logic [7:0] ADR_UPPER_TRIP_ASSERT_LEVEL  = 8'h18;
    localparam logic [7:0] ADR_UPPER_TRIP_RELEASE_LEVEL = 8'h19;
    localparam logic [7:0] ADR_LOWER_TRIP_ASSERT_LEVEL  = 8'h1A;
    localparam logic [7:0] ADR_LOWER_TRIP_RELEASE_LEVEL = 8'h1B;
    localparam logic [7:0] ADR_USER_CONFIG_WORD         = 8'h1C;
    localparam logic [7:0] ADR_RESERVED_WORD            = 8'h1D;
    localparam logic [7:0] ADR_USER_TAG_WORD_A          = 8'h1E;
    localparam logic [7:0] ADR_USER_TAG_WORD_B          = 8'h1F;
    localparam logic [15:0] NV_RESET [NV_WORDS] = '{16'h3FFF, 16'h0000, 16'h3FFF, 16'h3FFF,
        16'h0000, 16'h0000, 16'h0028, 16'h0000, 16'h0000, 16'h0000};
    localparam int CFG_IDX = 6;

    // user_config_word fields
    localparam int CFG_ADDR_MSB  = 6;
    localparam int CFG_SLEEP_BIT = 12;
    localparam int CFG_QUICK_BIT = 13;
    localparam int CFG_RDYOD_BIT = 14;

    // command bytes
    localparam logic [7:0] CMD_RD_LO = 8'h16;
    localparam logic [7:0] CMD_RD_HI = 8'h1F;
    localparam logic [7:0] CMD_WR_LO = 8'h56;
    localparam logic [7:0] CMD_WR_HI = 8'h5F;
    localparam logic [7:0] CMD_LEAVE = 8'h80;
    localparam logic [7:0] CMD_ENTER = 8'hA0;

    // status and response codes
    localparam logic [1:0] ST_FRESH   = 2'h0;
    localparam logic [1:0] ST_STALE   = 2'h1;
    localparam logic [1:0] ST_SESSION = 2'h2;
    localparam logic [1:0] RSP_BUSY   = 2'h0;
    localparam logic [1:0] RSP_OK     = 2'h1;
    localparam logic [1:0] RSP_NAK    = 2'h2;
    localparam int DATA_W = 14;

    typedef enum {LK_IDLE, LK_RX, LK_RXACK, LK_TX, LK_TXACK} hsc_link_t;
    typedef enum {MD_WINDOW, MD_SESSION, MD_NORMAL} hsc_mode_t;
endpackage

// *** hsc_bus_master.sv ***
`timescale 1ns/1ps
module hsc_bus_master
(
    output logic      scl,
    output logic      sdaDrv,
    input  wire logic sda
);
    // bus at rest: both lines high, the clock stands still
    initial
    begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    // data falls while the clock is high
    task start();
        #80 sdaDrv = 1'b0;
        #80 scl = 1'b0;
    endtask
    // data rises while the clock is high
    task stop();
        #20 sdaDrv = 1'b0;
        #60 scl = 1'b1;
        #80 sdaDrv = 1'b1;
        #160;
    endtask
    // nine bits, msb first; data moves 20 ns into the low phase so no false start or stop is seen
    task xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--)
        begin
            #20 sdaDrv = d[i];
            #60 scl = 1'b1;
            #40 q[i] = sda;
            #40 scl = 1'b0;
        end
    endtask
endmodule

// *** humidity_sensor_i2c_command_port_test.sv ***
`timescale 1ns/1ps
module humidity_sensor_i2c_command_port_test;
    import hsc_pkg::*;
    logic        mclk = 1'b0, rst_n = 1'b0, measDone = 1'b0, nvLocked = 1'b0, coreGo = 1'b0;
    logic        od = 1'b0;
    logic        scl, sdaDrv, sdaOut, sdaOe, readyOut, readyOe, measReq, coreAwake;
    logic [13:0] humIn = 14'h0000, tempIn = 14'h0000;
    logic [3:0]  diagIn = 4'h0;
    logic [8:0]  q;
    logic [7:0]  rb [4];
    int          n_mismatch = 0, checks = 0, h, t, nReq = 0;
    // wired-and data line and a pulled-up ready pin, so both driver kinds are seen
    wire         sdaIn = sdaOe ? (sdaOut & sdaDrv) : sdaDrv;
    wire         readyPin = readyOe ? readyOut : 1'b1;
    always #2.5 mclk = ~mclk;
    hsc_bus_master bus (.scl(scl), .sdaDrv(sdaDrv), .sda(sdaIn));
    hsc_command_port #(.READ_CYC_P(20), .ENTER_CYC_P(20), .WRITE_CYC_P(50),
        .WINDOW_CYC_P(3000), .QUICK_CYC_P(1000)) dut (.mclk(mclk), .rst_n(rst_n), .scl(scl),
        .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .readyOut(readyOut), .readyOe(readyOe),
        .measReq(measReq), .coreAwake(coreAwake), .measDone(measDone), .humIn(humIn),
        .tempIn(tempIn), .nvLocked(nvLocked), .diagIn(diagIn));
    // core stand-in: ends a cycle only when allowed, so results hold during readout
    always @(posedge mclk)
    begin
        measDone <= coreAwake & coreGo & ~measDone;
        if (measDone)
            coreGo <= 1'b0;
        if (measReq)
            nReq <= nReq + 1;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // address frame then n bytes; last read byte answered with nack
    task frame(input logic rd, input int n);
        bus.start();
        bus.xfer({7'h28, rd, 1'b1}, q);
        chk(q[0], 1'b0);
        for (int i = 0; i < n; i++)
        begin
            bus.xfer(rd ? {8'hFF, i == n - 1} : {rb[i], 1'b1}, q);
            rb[i] = q[8:1];
        end
        bus.stop();
    endtask
    // command, wait for ready instead of polling, then fetch the response
    task cmd(input logic [7:0] c, input logic [15:0] d, input logic [1:0] code);
        rb[0] = c;
        rb[1] = d[15:8];
        rb[2] = d[7:0];
        frame(1'b0, 3);
        for (int i = 0; i < 20000 && readyPin !== 1'b1; i++)
            @(posedge mclk);
        chk(readyPin, 1'b1);
        chk({readyOe, readyOut}, od ? 2'b00 : 2'b11);
        if (code != 2'h3)
        begin
            frame(1'b1, 3);
            chk(rb[0], {2'b10, diagIn, code});
        end
    endtask
    // one measurement with fresh random results, read back in full
    task meas();
        h = $urandom_range(16383);
        t = $urandom_range(16383);
        @(posedge mclk);
        humIn <= h[13:0];
        tempIn <= t[13:0];
        coreGo <= 1'b1;
        repeat (2) @(posedge mclk);
        for (int i = 0; i < 20000 && coreGo; i++)
            @(posedge mclk);
        chk(coreGo, 1'b0);
        repeat (3) @(posedge mclk);
        chk(readyPin, 1'b1);
        frame(1'b1, 4);
        chk({rb[0], rb[1]}, {ST_FRESH, h[13:0]});
        chk({rb[2], rb[3][7:2]}, t[13:0]);
        chk(readyPin, 1'b0);
        frame(1'b1, 1);
        chk(rb[0][7:6], ST_STALE);
    endtask
    task wrap_up();
        if (n_mismatch == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog at 90k clock cycles, about 1.75 times the expected run of some 51k clock cycles
    initial
    begin
        #450000;
        n_mismatch++;
        wrap_up();
    end
    // main sequence: session, word map, writes, leave, sleep wake
    initial
    begin
        void'($urandom(32'h9bb0c61f));
        diagIn <= 4'($urandom);
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (5) @(posedge mclk);
        cmd(CMD_ENTER, 16'h0000, RSP_OK);
        for (int i = 0; i < NV_WORDS; i++)
        begin
            cmd(CMD_RD_LO + 8'(i), 16'h0000, RSP_OK);
            chk({rb[1], rb[2]}, NV_RESET[i]);
        end
        h = $urandom;
        cmd(8'h5E, h[15:0], RSP_OK);
        cmd(8'h1E, 16'h0000, RSP_OK);
        chk({rb[1], rb[2]}, h[15:0]);
        @(posedge mclk) nvLocked <= 1'b1;
        cmd(8'h5F, 16'h1234, RSP_NAK);
        @(posedge mclk) nvLocked <= 1'b0;
        cmd(8'h33, 16'h0000, RSP_NAK);
        od = 1'b1;
        cmd(8'h5C, 16'h5028, RSP_OK);
        cmd(CMD_LEAVE, 16'h0000, 2'h3);
        meas();
        repeat (50) @(posedge mclk);
        chk(coreAwake, 1'b0);
        frame(1'b0, 0);
        meas();
        chk(16'(nReq), 16'h0002);
        // second reset: the window now runs out and normal operation measures
        @(posedge mclk) rst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3100) @(posedge mclk);
        chk(coreAwake, 1'b1);
        meas();
        wrap_up();
    end
endmodule
